//--- rtl/prs_register_stack.sv
// Processor register stack: general banks, floating-point, working and relocation registers.
//
// Functional notes
// - Stack holds 48 words in total.
// - Status word bit 18 selects general bank.
// - Two banks of sixteen 32-bit registers.
// - General registers picked by 4-bit fields.
// - Even register holds high half of pair.
// - Four 64-bit floating-point registers, short or long.
// - Short write touches high half only.
// - Op code decides floating or general register.
// - Floating registers numbered 0, 2, 4, 6 only.
// - Eight 32-bit working registers, implicitly selected.
// - Key change reloads relocation from low storage.
// - New key indexes the relocation table.
// - Problem state offsets general registers by 16.
`timescale 1ns/1ps
`default_nettype none
module prs_register_stack (
   input  wire logic                              i_sys_clk,
   input  wire logic                              i_srst,
   input  wire logic [prs_pkg::PRS_PSW_W-1:0]     i_program_status_word,
   input  wire logic                              i_rd_en,
   input  wire logic [7:0]                        i_rd_opcode,
   input  wire logic                              i_rd_dbl,
   input  wire logic [prs_pkg::PRS_FIELD_W-1:0]   i_rd1_field,
   input  wire logic [prs_pkg::PRS_FIELD_W-1:0]   i_rd2_field,
   input  wire logic                              i_wr_en,
   input  wire logic [7:0]                        i_wr_opcode,
   input  wire logic                              i_wr_dbl,
   input  wire logic [prs_pkg::PRS_FIELD_W-1:0]   i_wr_field,
   input  wire logic [63:0]                       i_wr_data,
   input  wire logic                              i_wk_wr_en,
   input  wire logic [prs_pkg::PRS_WK_IDX_W-1:0]  i_wk_wr_idx,
   input  wire logic [prs_pkg::PRS_WORD_W-1:0]    i_wk_wr_data,
   input  wire logic [prs_pkg::PRS_WK_IDX_W-1:0]  i_wk_rd_idx,
   input  wire logic                              i_reloc_ack,
   input  wire logic [prs_pkg::PRS_WORD_W-1:0]    i_reloc_data,
   output logic [63:0]                            o_rd1_data,
   output logic [63:0]                            o_rd2_data,
   output logic                                   o_rd_valid,
   output logic [prs_pkg::PRS_WORD_W-1:0]         o_wk_rd_data,
   output logic                                   o_spec_err,
   output logic                                   o_reloc_req,
   output logic [prs_pkg::PRS_ADDR_W-1:0]         o_reloc_addr,
   output logic [prs_pkg::PRS_RELOC_W-1:0]        o_reloc_q,
   output logic                                   o_reloc_busy
);
   import prs_pkg::*;

   // ==========================================================================
   // Storage.
   // One flat array keeps the hardware word numbering visible in debug dumps.
   // Words 0 to 15 hold the supervisor general registers.
   // Words 16 to 31 hold the problem-state general registers.
   // Words 32 to 39 hold the four floating registers, two words each.
   // Words 40 to 47 hold the eight working registers.
   // The relocation register sits outside the stack, with the reload logic.
   logic [PRS_WORD_W-1:0]   stack_q [PRS_STACK_WORDS];

   logic                    problem_state_select;
   logic [PRS_KEY_W-1:0]    psw_key;

   // Status word fields, bit 0 being the most significant, so bit 18 lands
   // on vector position 45 and the key bits 8 to 11 on positions 55 to 52.
   assign problem_state_select = i_program_status_word[PRS_PSW_PR_POS];
   assign psw_key = i_program_status_word[PRS_PSW_KEY_POS -: PRS_KEY_W];

   // ==========================================================================
   // Register number decode.
   // A general field maps to bank base 0 or 16 by the problem-state bit; a
   // floating-point field is an offset into the block starting at word 32.
   function automatic logic [PRS_IDX_W-1:0] gr_index(input logic                   pr,
                                                     input logic [PRS_FIELD_W-1:0] fld);
      return {1'b0, pr, fld};
   endfunction

   function automatic logic [PRS_IDX_W-1:0] fp_index(input logic [PRS_FIELD_W-1:0] fld);
      return PRS_FP_BASE + {2'b00, fld};
   endfunction

   // A field is legal when floating numbers are even and no more than six,
   // and when a general pair starts on an even register.
   function automatic logic field_ok(input logic                   is_fp,
                                     input logic                   dbl,
                                     input logic [PRS_FIELD_W-1:0] fld);
      logic ok;
      ok = 1'b1;
      if (is_fp) begin
         ok = (fld[0] == 1'b0) && (fld <= PRS_FP_MAX_FIELD);
      end else if (dbl) begin
         ok = (fld[0] == 1'b0);
      end
      return ok;
   endfunction

   // Read one operand: general single sits in the high half, pairs and
   // floating registers return even word high and odd word low.
   function automatic logic [63:0] read_operand(input logic                   is_fp,
                                                input logic                   dbl,
                                                input logic                   pr,
                                                input logic [PRS_FIELD_W-1:0] fld,
                                                input logic [PRS_WORD_W-1:0]  words [PRS_STACK_WORDS]);
      logic [PRS_IDX_W-1:0] hi;
      logic [63:0]          val;
      hi  = is_fp ? fp_index(fld) : gr_index(pr, fld);
      val = {words[hi], PRS_WORD_RESET};
      if (is_fp || dbl) begin
         val[31:0] = words[hi + 6'h01];
      end
      return val;
   endfunction

   // ==========================================================================
   // Operand classification for both ports.
   logic                    rd_is_fp;
   logic                    wr_is_fp;
   logic                    rd_ok;
   logic                    wr_ok;
   logic [PRS_IDX_W-1:0]    wr_hi_idx;
   logic [PRS_IDX_W-1:0]    wr_lo_idx;
   logic                    wr_lo_en;
   logic                    wr_fp_long;

   // The op code alone tells whether a field names a floating register.
   assign rd_is_fp = prs_is_fp_op(i_rd_opcode);
   assign wr_is_fp = prs_is_fp_op(i_wr_opcode);

   // One bad field refuses the whole read; a write carries one field only.
   assign rd_ok = field_ok(rd_is_fp, i_rd_dbl, i_rd1_field)
                  && field_ok(rd_is_fp, i_rd_dbl, i_rd2_field);
   assign wr_ok = field_ok(wr_is_fp, i_wr_dbl, i_wr_field);

   // For floating writes the dbl input means a long result; a short result
   // only updates the high word and leaves the low word untouched.
   assign wr_fp_long = wr_is_fp && i_wr_dbl;
   assign wr_hi_idx  = wr_is_fp ? fp_index(i_wr_field)
                                : gr_index(problem_state_select, i_wr_field);
   assign wr_lo_idx  = wr_hi_idx + 6'h01;
   assign wr_lo_en   = wr_is_fp ? wr_fp_long : i_wr_dbl;

   // ==========================================================================
   // Stack writes, one slice of logic per word.
   // A write with an illegal field is dropped entirely so no half pair lands.
   // Each word compares the decoded indices against its own number; the three
   // write sources never meet on one word because general, floating and
   // working words sit in separate ranges of the stack.
   logic                    wr_take;
   logic [PRS_IDX_W-1:0]    wk_wr_slot;

   assign wr_take    = i_wr_en && wr_ok;
   assign wk_wr_slot = PRS_WK_BASE + {3'b000, i_wk_wr_idx};

   for (genvar w = 0; w < PRS_STACK_WORDS; w++) begin : g_word
      localparam logic [PRS_IDX_W-1:0] WORD_IDX = PRS_IDX_W'(w);

      logic                 hi_hit;
      logic                 lo_hit;
      logic                 wk_hit;

      assign hi_hit = wr_take && (wr_hi_idx == WORD_IDX);
      assign lo_hit = wr_take && wr_lo_en && (wr_lo_idx == WORD_IDX);
      assign wk_hit = i_wk_wr_en && (wk_wr_slot == WORD_IDX);

      // Reset clears every word, so reads after reset return zero.
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            stack_q[w] <= PRS_WORD_RESET;
         end else if (hi_hit) begin
            stack_q[w] <= i_wr_data[63:32];
         end else if (lo_hit) begin
            stack_q[w] <= i_wr_data[31:0];
         end else if (wk_hit) begin
            stack_q[w] <= i_wk_wr_data;
         end
      end
   end

   // ==========================================================================
   // Read ports, registered one cycle after the request.
   // Reads see the stack as it stood before this edge, so a read of a word
   // written in the same cycle returns the old contents. A refused read
   // leaves the data outputs as they were.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_rd1_data <= {PRS_WORD_RESET, PRS_WORD_RESET};
         o_rd2_data <= {PRS_WORD_RESET, PRS_WORD_RESET};
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_en && rd_ok;
         if (i_rd_en && rd_ok) begin
            o_rd1_data <= read_operand(rd_is_fp, i_rd_dbl, problem_state_select,
                                       i_rd1_field, stack_q);
            o_rd2_data <= read_operand(rd_is_fp, i_rd_dbl, problem_state_select,
                                       i_rd2_field, stack_q);
         end
      end
   end

   // Working register read is continuous through a register stage.
   // The working index is decoded apart from the general and floating path
   // because the op code, not a register field, selects it.
   logic [PRS_IDX_W-1:0]    wk_rd_slot;

   assign wk_rd_slot = PRS_WK_BASE + {3'b000, i_wk_rd_idx};

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_wk_rd_data <= PRS_WORD_RESET;
      end else begin
         o_wk_rd_data <= stack_q[wk_rd_slot];
      end
   end

   // Specification error is a one-cycle pulse for any bad read or write.
   // A bad read and a bad write in one cycle still give a single pulse.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_spec_err <= 1'b0;
      end else begin
         o_spec_err <= (i_rd_en && !rd_ok) || (i_wr_en && !wr_ok);
      end
   end

   // ==========================================================================
   // Relocation reload.
   // The last key seen is tracked; any difference starts a fetch of the table
   // entry the new key points to. A key that changes again mid-fetch is
   // caught on return, at the cost of one wasted fetch.
   prs_reload_state_t       rl_state_q;
   logic [PRS_KEY_W-1:0]    key_q;
   logic [PRS_KEY_W-1:0]    fetch_key_q;
   logic                    key_changed;
   logic [PRS_ADDR_W-1:0]   entry_addr;

   assign key_changed = (psw_key != key_q);

   // Each table entry is one word, so the key is scaled by four bytes.
   assign entry_addr = PRS_RELOC_TBL_BASE + {18'h0_0000, psw_key, 2'b00};

   // The key memory follows the status word every cycle. It resets to zero,
   // so a nonzero key present when reset ends starts a reload at once.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         key_q <= '0;
      end else begin
         key_q <= psw_key;
      end
   end

   // The request stands until storage acknowledges the entry of the key that
   // is current at that moment. Busy mirrors the request so that the execute
   // side can hold off address sums while the factor is stale. Acknowledges
   // that arrive while idle are ignored.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rl_state_q   <= PRS_RL_IDLE;
         fetch_key_q  <= '0;
         o_reloc_req  <= 1'b0;
         o_reloc_busy <= 1'b0;
         o_reloc_addr <= PRS_RELOC_TBL_BASE;
      end else begin
         unique case (rl_state_q)
            PRS_RL_IDLE: begin
               if (key_changed) begin
                  rl_state_q   <= PRS_RL_FETCH;
                  fetch_key_q  <= psw_key;
                  o_reloc_req  <= 1'b1;
                  o_reloc_busy <= 1'b1;
                  o_reloc_addr <= entry_addr;
               end
            end
            PRS_RL_FETCH: begin
               if (i_reloc_ack) begin
                  if (psw_key != fetch_key_q) begin
                     // The key moved during the fetch, so the new entry is asked for.
                     fetch_key_q  <= psw_key;
                     o_reloc_addr <= entry_addr;
                  end else begin
                     // The entry just taken belongs to the current key.
                     rl_state_q   <= PRS_RL_IDLE;
                     o_reloc_req  <= 1'b0;
                     o_reloc_busy <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // The factor is taken on every acknowledge of a pending fetch, even one
   // about to be superseded, so it is never older than the last finished fetch.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_reloc_q <= PRS_RELOC_RESET;
      end else if ((rl_state_q == PRS_RL_FETCH) && i_reloc_ack) begin
         o_reloc_q <= i_reloc_data[PRS_RELOC_W-1:0];
      end
   end
endmodule
`default_nettype wire

//--- inc/prs_pkg.sv
// Constants and helper functions shared by the processor register stack.
`default_nettype none
package prs_pkg;
   // ==========================================================================
   // Stack geometry.
   localparam int          PRS_STACK_WORDS  = 48;
   localparam int          PRS_WORD_W       = 32;
   localparam int          PRS_IDX_W        = 6;
   localparam int          PRS_FIELD_W      = 4;
   localparam int          PRS_WK_COUNT     = 8;
   localparam int          PRS_WK_IDX_W     = 3;
   localparam logic [5:0]  PRS_FP_BASE      = 6'h20;
   localparam logic [5:0]  PRS_WK_BASE      = 6'h28;
   localparam logic [3:0]  PRS_FP_MAX_FIELD = 4'h6;

   // ==========================================================================
   // Status word layout; bit 0 is the most significant bit.
   localparam int PRS_PSW_W       = 64;
   localparam int PRS_PSW_PR_BIT  = 18;
   localparam int PRS_PSW_KEY_BIT = 8;
   localparam int PRS_PSW_PR_POS  = PRS_PSW_W - 1 - PRS_PSW_PR_BIT;
   localparam int PRS_PSW_KEY_POS = PRS_PSW_W - 1 - PRS_PSW_KEY_BIT;
   localparam int PRS_KEY_W       = 4;

   // ==========================================================================
   // Relocation reload.
   localparam int           PRS_RELOC_W        = 20;
   localparam int           PRS_ADDR_W         = 24;
   localparam logic [23:0]  PRS_RELOC_TBL_BASE = 24'h00_0080;
   localparam logic [19:0]  PRS_RELOC_RESET    = 20'h0_0000;
   localparam logic [31:0]  PRS_WORD_RESET     = 32'h0000_0000;

   typedef enum logic [0:0] {
      PRS_RL_IDLE  = 1'b0,
      PRS_RL_FETCH = 1'b1
   } prs_reload_state_t;

   // ==========================================================================
   // Floating-point operation classes have op code bit 7 clear and bit 5 set.
   function automatic logic prs_is_fp_op(input logic [7:0] opcode);
      return (opcode[7] == 1'b0) && (opcode[5] == 1'b1);
   endfunction
endpackage
`default_nettype wire

//--- tb/prs_stack_checker_assertions.sv
// Port-level concurrent checks for the processor register stack.
`timescale 1ns/1ps
`default_nettype none
module prs_stack_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_srst,
   input wire logic [63:0] i_program_status_word,
   input wire logic        i_rd_en,
   input wire logic [7:0]  i_rd_opcode,
   input wire logic        i_rd_dbl,
   input wire logic [3:0]  i_rd1_field,
   input wire logic        i_wr_en,
   input wire logic [7:0]  i_wr_opcode,
   input wire logic        i_wr_dbl,
   input wire logic [3:0]  i_wr_field,
   input wire logic        i_reloc_ack,
   input wire logic [31:0] i_reloc_data,
   input wire logic [63:0] o_rd1_data,
   input wire logic        o_rd_valid,
   input wire logic        o_spec_err,
   input wire logic        o_reloc_req,
   input wire logic [23:0] o_reloc_addr,
   input wire logic [19:0] o_reloc_q
);
   // ====================
   // Request legality; the bench keeps both read fields of one parity, so field one decides.
   wire logic rfp = !i_rd_opcode[7] && i_rd_opcode[5];
   wire logic wfp = !i_wr_opcode[7] && i_wr_opcode[5];
   wire logic bad_rd = i_rd_en && (rfp ? (i_rd1_field[0] || i_rd1_field > 4'h6)
                                       : (i_rd_dbl && i_rd1_field[0]));
   wire logic bad_wr = i_wr_en && (wfp ? (i_wr_field[0] || i_wr_field > 4'h6)
                                       : (i_wr_dbl && i_wr_field[0]));
   wire logic [3:0]  key  = i_program_status_word[55:52];
   wire logic [23:0] eadr = 24'h00_0080 + {18'h0_0000, key, 2'b00};
   wire logic [19:0] rdat = i_reloc_data[19:0];
   logic [3:0]       key_q;
   // Key of the previous edge; cleared in reset like the stored key, so no false start.
   always_ff @(posedge i_sys_clk) begin
      key_q <= i_srst ? 4'h0 : key;
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // ====================
   // Properties.
   property p_rd_ok;   i_rd_en && !bad_rd |=> o_rd_valid; endproperty
   property p_rd_bad;  bad_rd |=> o_spec_err && !o_rd_valid && $stable(o_rd1_data); endproperty
   property p_idle;    !i_rd_en |=> !o_rd_valid; endproperty
   property p_wr_bad;  bad_wr |=> o_spec_err; endproperty
   property p_no_err;  !bad_rd && !bad_wr |=> !o_spec_err; endproperty
   property p_rl_go;   key != key_q && !o_reloc_req |=>
                       o_reloc_req && o_reloc_addr == $past(eadr); endproperty
   property p_rl_hold; o_reloc_req && !i_reloc_ack |=> o_reloc_req && $stable(o_reloc_q);
   endproperty
   property p_rl_load; o_reloc_req && i_reloc_ack |=> o_reloc_q == $past(rdat); endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("legal read gave no valid");
   a_rd_bad: assert property (p_rd_bad) else $error("bad read not refused");
   a_idle: assert property (p_idle) else $error("valid without read");
   a_wr_bad: assert property (p_wr_bad) else $error("bad write not flagged");
   a_no_err: assert property (p_no_err) else $error("error without cause");
   a_rl_go: assert property (p_rl_go) else $error("reload not started");
   a_rl_hold: assert property (p_rl_hold) else $error("reload dropped early");
   a_rl_load: assert property (p_rl_load) else $error("reload value lost");
   c_rd: cover property (i_rd_en && !bad_rd);
   c_bad: cover property (bad_rd);
   c_rl: cover property (o_reloc_req && i_reloc_ack);
endmodule
bind prs_register_stack prs_stack_checker u_prs_stack_checker (
   .i_sys_clk, .i_srst, .i_program_status_word, .i_rd_en, .i_rd_opcode, .i_rd_dbl,
   .i_rd1_field, .i_wr_en, .i_wr_opcode, .i_wr_dbl, .i_wr_field, .i_reloc_ack,
   .i_reloc_data, .o_rd1_data, .o_rd_valid, .o_spec_err, .o_reloc_req, .o_reloc_addr,
   .o_reloc_q
);
`default_nettype wire

//--- tb/prs_storage_model.sv
// Low-storage responder that returns relocation entries.
`timescale 1ns/1ps
`default_nettype none
module prs_storage_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_slow,
   input  wire logic        i_reloc_req,
   input  wire logic [23:0] i_reloc_addr,
   output logic             o_reloc_ack,
   output logic [31:0]      o_reloc_data
);
   logic [2:0] wait_q;
   wire  logic fire = i_reloc_req && !o_reloc_ack && (wait_q == (i_slow ? 3'h4 : 3'h0));
   // Answer after one or five cycles; ack only while a fetch is pending.
   always_ff @(posedge i_sys_clk) begin
      wait_q <= (i_srst || !i_reloc_req || o_reloc_ack) ? 3'h0 : wait_q + 3'h1;
      o_reloc_ack <= !i_srst && fire;
   end
   // Data is inverted every idle cycle so that a late capture shows up as a mismatch.
   always_ff @(posedge i_sys_clk) begin
      o_reloc_data <= i_srst ? 32'h5A5A_5A5A : (fire ? {8'hC3, i_reloc_addr} : ~o_reloc_data);
   end
endmodule
`default_nettype wire

//--- tb/tb_prs_register_stack.sv
// Self-checking bench for the processor register stack.
`timescale 1ns/1ps
`default_nettype none
module tb_prs_register_stack;
   import prs_pkg::*;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
   logic        i_sys_clk = 1'b0, i_srst = 1'b1, i_rd_en = 1'b0, i_rd_dbl = 1'b0, slow = 1'b0;
   logic        i_wr_en = 1'b0, i_wr_dbl = 1'b0, i_wk_wr_en = 1'b0, i_reloc_ack;
   logic        o_rd_valid, o_spec_err, o_reloc_req, o_reloc_busy;
   logic [63:0] i_program_status_word = '0, i_wr_data = '0, o_rd1_data, o_rd2_data;
   logic [7:0]  i_rd_opcode = '0, i_wr_opcode = '0;
   logic [3:0]  i_rd1_field = '0, i_rd2_field = '0, i_wr_field = '0;
   logic [2:0]  i_wk_wr_idx = '0, i_wk_rd_idx = '0;
   logic [31:0] i_wk_wr_data = '0, i_reloc_data, o_wk_rd_data, m [48];
   logic [23:0] o_reloc_addr;
   logic [19:0] o_reloc_q;
   int          fail_count = 0, total_checks = 0;
   prs_register_stack u_prs_register_stack (.i_sys_clk, .i_srst, .i_program_status_word,
      .i_rd_en, .i_rd_opcode, .i_rd_dbl, .i_rd1_field, .i_rd2_field, .i_wr_en, .i_wr_opcode,
      .i_wr_dbl, .i_wr_field, .i_wr_data, .i_wk_wr_en, .i_wk_wr_idx, .i_wk_wr_data,
      .i_wk_rd_idx, .i_reloc_ack, .i_reloc_data, .o_rd1_data, .o_rd2_data, .o_rd_valid,
      .o_wk_rd_data, .o_spec_err, .o_reloc_req, .o_reloc_addr, .o_reloc_q, .o_reloc_busy);
   prs_storage_model u_prs_storage_model (.i_sys_clk, .i_srst, .i_slow(slow),
      .i_reloc_req(o_reloc_req), .i_reloc_addr(o_reloc_addr), .o_reloc_ack(i_reloc_ack),
      .o_reloc_data(i_reloc_data));
   initial forever #2.5 i_sys_clk = ~i_sys_clk;
   // ====================
   // Reference model: stack slot, legality and read value of a field.
   function automatic logic legal(logic fp, logic dbl, logic [3:0] f);
      return fp ? (!f[0] && f <= 4'h6) : !(dbl && f[0]);
   endfunction
   function automatic logic [5:0] slot(logic fp, logic pr, logic [3:0] f);
      return fp ? 6'h20 + {2'b00, f} : {1'b0, pr, f};
   endfunction
   function automatic logic [63:0] rdexp(logic fp, logic dbl, logic pr, logic [3:0] f);
      logic [5:0] s;
      s = slot(fp, pr, f);
      return {m[s], (fp || dbl) ? m[s + 6'h01] : 32'h0000_0000};
   endfunction
   // Wait out a pending reload, bounded so a stuck request cannot hang the run.
   task automatic wait_idle();
      for (int n = 0; n < 20 && o_reloc_req !== 1'b0; n++) @(posedge i_sys_clk) #1;
      `CHK(o_reloc_req, 1'b0)
      `CHK(o_reloc_busy, 1'b0)
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ====================
   // Watchdog; the whole sequence needs well under a thousand cycles.
   initial begin
      #20us;
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      final_report();
   end
   // ====================
   // Main sequence.
   initial begin
      logic [63:0] e1, e2;
      logic [31:0] r, s, ew;
      logic [5:0]  ws;
      logic        ev, ee, rfp, wfp;
      foreach (m[i]) m[i] = 32'h0000_0000;
      void'($urandom(79));
      repeat (10) @(posedge i_sys_clk);
      #1 i_srst = 1'b0;
      // Every nonzero key, storage alternately prompt and slow.
      for (int k = 1; k < 16; k++) begin
         slow = k[0];
         i_program_status_word[55:52] = k[3:0];
         @(posedge i_sys_clk) #1;
         `CHK(o_reloc_busy, 1'b1)
         wait_idle();
         `CHK(o_reloc_q, 20'h0_0080 + 20'(k * 4))
      end
      // Key moves again mid-fetch; the last key's entry must win.
      i_program_status_word[55:52] = 4'h3;
      @(posedge i_sys_clk) #1 i_program_status_word[55:52] = 4'h9;
      @(posedge i_sys_clk) #1 wait_idle();
      `CHK(o_reloc_q, 20'h0_00A4)
      $display("reload test done");
      {e1, e2} = '0;
      repeat (400) begin
         r = $urandom;
         s = $urandom;
         {i_wr_field, i_rd1_field, i_wr_opcode, i_rd_opcode} = r[31:8];
         {i_program_status_word[45], i_wk_wr_en, i_wr_dbl, i_rd_dbl, i_wr_en, i_rd_en} = r[5:0];
         // Corner: read the very register written at the same edge, which must not bypass.
         if (s[1:0] == 2'b00) {i_rd1_field, i_rd_opcode} = {i_wr_field, i_wr_opcode};
         i_rd2_field = i_rd1_field ^ 4'h2;
         i_wr_data = {$urandom, $urandom};
         i_wk_wr_idx = s[4:2];
         i_wk_rd_idx = s[4:2] + 3'h1 + 3'(s[7:5] % 7);
         i_wk_wr_data = $urandom;
         rfp = !i_rd_opcode[7] && i_rd_opcode[5];
         wfp = !i_wr_opcode[7] && i_wr_opcode[5];
         ev = i_rd_en && legal(rfp, i_rd_dbl, i_rd1_field);
         ee = (i_rd_en && !ev) || (i_wr_en && !legal(wfp, i_wr_dbl, i_wr_field));
         if (ev) e1 = rdexp(rfp, i_rd_dbl, r[5], i_rd1_field);
         if (ev) e2 = rdexp(rfp, i_rd_dbl, r[5], i_rd2_field);
         ew = m[6'h28 + {3'b000, i_wk_rd_idx}];
         ws = slot(wfp, r[5], i_wr_field);
         if (i_wr_en && legal(wfp, i_wr_dbl, i_wr_field)) begin
            m[ws] = i_wr_data[63:32];
            if (i_wr_dbl) m[ws + 6'h01] = i_wr_data[31:0];
         end
         if (i_wk_wr_en) m[6'h28 + {3'b000, i_wk_wr_idx}] = i_wk_wr_data;
         @(posedge i_sys_clk) #1;
         `CHK(o_rd_valid, ev)
         `CHK(o_spec_err, ee)
         `CHK(o_rd1_data, e1)
         `CHK(o_rd2_data, e2)
         `CHK(o_wk_rd_data, ew)
      end
      $display("random test done");
      // Mid-run reset: outputs clear and the address goes to the table base, then the nonzero key reloads at once.
      {i_rd_en, i_wr_en, i_wk_wr_en} = 3'b000;
      i_srst = 1'b1;
      @(posedge i_sys_clk) #1;
      `CHK({o_rd_valid, o_spec_err, o_reloc_req, o_reloc_busy}, 4'h0)
      `CHK({o_rd1_data, o_rd2_data, o_wk_rd_data, o_reloc_q}, 180'h0)
      `CHK(o_reloc_addr, 24'h00_0080)
      foreach (m[i]) m[i] = 32'h0000_0000;
      i_srst = 1'b0;
      @(posedge i_sys_clk) #1;
      `CHK(o_reloc_addr, 24'h00_00A4)
      wait_idle();
      `CHK(o_reloc_q, 20'h0_00A4)
      $display("reset test done");
      final_report();
   end
endmodule
`default_nettype wire
